// ---- sim_serial_pkg.sv ----
// constants, register map and state codes of the smart-card serial channel
package sim_serial_pkg;

   // register byte offsets on the lite bus
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_BRG   = 8'h04;
   localparam logic [7:0] OFS_TXBUF = 8'h08;
   localparam logic [7:0] OFS_RXBUF = 8'h0C;
   localparam logic [7:0] OFS_STAT  = 8'h10;
   localparam logic [7:0] OFS_ISTAT = 8'h14;
   localparam logic [7:0] OFS_IMASK = 8'h18;

   // control register fields
   localparam int CB_TX_EN   = 0;
   localparam int CB_RX_EN   = 1;
   localparam int CB_PAR_EN  = 2;
   localparam int CB_PAR_SEL = 3;
   localparam int CB_ORDER   = 4;
   localparam int CB_INV     = 5;
   localparam int CB_ERE     = 6;
   localparam logic [7:0] CTRL_RST = 8'h0C;

   // bit period is brg+1 clocks
   localparam logic [15:0] BRG_RST = 16'h01B1;

   // receive buffer error fields
   localparam int RB_OVR = 12;
   localparam int RB_FRM = 13;
   localparam int RB_PAR = 14;
   localparam int RB_SUM = 15;

   // status register fields
   localparam int SB_TXB_EMPTY = 0;
   localparam int SB_TX_IDLE   = 1;
   localparam int SB_RX_FULL   = 2;
   localparam int SB_RX_PIN    = 3;
   localparam int SB_ERR_SIG   = 4;

   // interrupt status and mask fields
   localparam int IB_TX_DONE = 0;
   localparam int IB_RX_DONE = 1;
   localparam int IB_RX_ERR  = 2;
   localparam int IRQ_W      = 3;
   localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

   // frame and bus constants
   localparam logic [2:0] LAST_DATA_IDX = 3'h7;
   localparam logic       LINE_IDLE     = 1'b1;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   // character framing states, shared by transmitter and receiver
   typedef enum logic [4:0] {
      FR_IDLE  = 5'h01,
      FR_START = 5'h02,
      FR_DATA  = 5'h04,
      FR_PAR   = 5'h08,
      FR_STOP  = 5'h10
   } frame_state_t;

endpackage

// ---- pin_sync3.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync3
   import sim_serial_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic pin_in,
   output logic      level_out
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   // first stage feeds only the second; output moves once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_reg    <= LINE_IDLE;
         s2_reg    <= LINE_IDLE;
         s3_reg    <= LINE_IDLE;
         level_out <= LINE_IDLE;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            level_out <= s3_reg;
         end
      end
   end
endmodule
`default_nettype wire

// ---- sim_card_serial_mode.sv ----
// smart-card serial channel with lite-bus registers and parity error signalling
`timescale 1ns/1ps
`default_nettype none
module sim_card_serial_mode
   import sim_serial_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        serial_rx_pin,
   output logic             serial_tx_pin,
   output logic             irq
);

   function automatic logic [7:0] reverse8(input logic [7:0] d);
      logic [7:0] r;
      r = 8'h00;
      for (int k = 0; k < 8; k++) begin
         r[k] = d[7-k];
      end
      return r;
   endfunction

   logic [7:0]       waddr_reg;
   logic [31:0]      wdata_reg;
   logic [3:0]       wstrb_reg;
   logic [7:0]       ctrl_reg;
   logic [15:0]      brg_reg;
   logic [7:0]       tx_buffer;
   logic             tx_full_reg;
   logic [7:0]       rx_buffer;
   logic             rx_full_reg;
   logic             oer_reg;
   logic             fer_reg;
   logic             per_reg;
   logic             err_sig_reg;
   logic [IRQ_W-1:0] istat_reg;
   logic [IRQ_W-1:0] imask_reg;
   frame_state_t     tx_state_reg;
   logic             rx_line;
   logic             do_write;
   logic             rd_rxbuf;
   logic [31:0]      rd_mux;
   logic             rd_ok;
   logic             wr_ok;

   wire parity_enable       = ctrl_reg[CB_PAR_EN];
   wire parity_odd_even_sel = ctrl_reg[CB_PAR_SEL];
   wire bit_order_sel       = ctrl_reg[CB_ORDER];
   wire data_invert_sel     = ctrl_reg[CB_INV];
   wire error_signal_out_en = ctrl_reg[CB_ERE];

   // receive pin passes three stages before any logic looks at it
   pin_sync3 u_rx_sync (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .pin_in    (serial_rx_pin),
      .level_out (rx_line)
   );

   // ---------------- lite bus slave ----------------
   assign do_write = !awready && !wready && !bvalid;
   assign rd_rxbuf = arvalid && arready && (araddr == OFS_RXBUF);

   // address and data are taken in either order; response once both are in
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready   <= 1'b1;
         wready    <= 1'b1;
         bvalid    <= 1'b0;
         bresp     <= RESP_OKAY;
         waddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            awready   <= 1'b0;
            waddr_reg <= awaddr;
         end
         if (wvalid && wready) begin
            wready    <= 1'b0;
            wdata_reg <= wdata;
            wstrb_reg <= wstrb;
         end
         if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // writable offsets; status and receive buffer are read-only
   always_comb begin
      case (waddr_reg)
         OFS_CTRL, OFS_BRG, OFS_TXBUF, OFS_ISTAT, OFS_IMASK: wr_ok = 1'b1;
         default:                                         wr_ok = 1'b0;
      endcase
   end

   // read data selection
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_ok  = 1'b1;
      case (araddr)
         OFS_CTRL:  rd_mux[7:0]  = ctrl_reg;
         OFS_BRG:   rd_mux[15:0] = brg_reg;
         OFS_TXBUF: rd_mux[7:0]  = tx_buffer;
         OFS_RXBUF: begin
            rd_mux[7:0]   = rx_buffer;
            rd_mux[RB_OVR] = oer_reg;
            rd_mux[RB_FRM] = fer_reg;
            rd_mux[RB_PAR] = per_reg;
            rd_mux[RB_SUM] = oer_reg | fer_reg | per_reg;
         end
         OFS_STAT: begin
            rd_mux[SB_TXB_EMPTY] = !tx_full_reg;
            rd_mux[SB_TX_IDLE]   = 1'b0;
            rd_mux[SB_RX_FULL]   = rx_full_reg;
            rd_mux[SB_RX_PIN]    = rx_line;
            rd_mux[SB_ERR_SIG]   = err_sig_reg;
         end
         OFS_ISTAT: rd_mux[IRQ_W-1:0] = istat_reg;
         OFS_IMASK: rd_mux[IRQ_W-1:0] = imask_reg;
         default:   rd_ok = 1'b0;
      endcase
   end

   // one read in flight; data registered at the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= RESP_OKAY;
      end else begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_mux;
            rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            if (araddr == OFS_STAT) begin
               rdata[SB_TX_IDLE] <= (tx_state_reg == FR_IDLE) && !tx_full_reg;
            end
         end
         if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   // control, bit rate and mask registers with byte lanes honoured
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg  <= CTRL_RST;
         brg_reg   <= BRG_RST;
         imask_reg <= IRQ_RST;
      end else if (do_write) begin
         if (waddr_reg == OFS_CTRL && wstrb_reg[0]) begin
            ctrl_reg <= wdata_reg[7:0];
         end
         if (waddr_reg == OFS_BRG && wstrb_reg[0]) begin
            brg_reg[7:0] <= wdata_reg[7:0];
         end
         if (waddr_reg == OFS_BRG && wstrb_reg[1]) begin
            brg_reg[15:8] <= wdata_reg[15:8];
         end
         if (waddr_reg == OFS_IMASK && wstrb_reg[0]) begin
            imask_reg <= wdata_reg[IRQ_W-1:0];
         end
      end
   end

   // ---------------- transmitter ----------------
   logic [15:0]  tx_cnt_reg;
   logic [2:0]   tx_idx_reg;
   logic [7:0]   tx_shift_reg;
   logic         tx_par_reg;
   logic         tx_line_reg;
   logic         tx_done;
   logic         tx_load;
   logic [7:0]   tx_prep;
   wire          tx_tick = (tx_cnt_reg == 16'h0000);

   assign tx_load = (tx_state_reg == FR_IDLE) && tx_full_reg && ctrl_reg[CB_TX_EN];
   assign tx_done = (tx_state_reg == FR_STOP) && tx_tick;

   // order and polarity applied before shifting; shifter always sends bit 0 first
   always_comb begin
      tx_prep = bit_order_sel ? reverse8(tx_buffer) : tx_buffer;
      tx_prep = tx_prep ^ {8{data_invert_sel}};
   end

   // transmit buffer: write fills it, the shifter empties it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_buffer   <= 8'h00;
         tx_full_reg <= 1'b0;
      end else begin
         if (tx_load) begin
            tx_full_reg <= 1'b0;
         end
         if (do_write && waddr_reg == OFS_TXBUF && wstrb_reg[0]) begin
            tx_buffer   <= wdata_reg[7:0];
            tx_full_reg <= 1'b1;
         end
      end
   end

   // character framing on the transmit side
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_state_reg <= FR_IDLE;
         tx_cnt_reg   <= 16'h0000;
         tx_idx_reg   <= 3'h0;
         tx_shift_reg <= 8'h00;
         tx_par_reg   <= 1'b0;
         tx_line_reg  <= LINE_IDLE;
      end else begin
         if (!tx_tick) begin
            tx_cnt_reg <= tx_cnt_reg - 16'h0001;
         end
         case (tx_state_reg)
            FR_IDLE: begin
               tx_line_reg <= LINE_IDLE;
               if (tx_load) begin
                  tx_shift_reg <= tx_prep;
                  tx_par_reg   <= (^tx_prep) ^ !parity_odd_even_sel;
                  tx_line_reg  <= 1'b0;
                  tx_cnt_reg   <= brg_reg;
                  tx_state_reg <= FR_START;
               end
            end
            FR_START: begin
               if (tx_tick) begin
                  tx_line_reg  <= tx_shift_reg[0];
                  tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                  tx_idx_reg   <= 3'h0;
                  tx_cnt_reg   <= brg_reg;
                  tx_state_reg <= FR_DATA;
               end
            end
            FR_DATA: begin
               if (tx_tick) begin
                  tx_cnt_reg <= brg_reg;
                  if (tx_idx_reg == LAST_DATA_IDX) begin
                     if (parity_enable) begin
                        tx_line_reg  <= tx_par_reg;
                        tx_state_reg <= FR_PAR;
                     end else begin
                        tx_line_reg  <= LINE_IDLE;
                        tx_state_reg <= FR_STOP;
                     end
                  end else begin
                     tx_line_reg  <= tx_shift_reg[0];
                     tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                     tx_idx_reg   <= tx_idx_reg + 3'h1;
                  end
               end
            end
            FR_PAR: begin
               if (tx_tick) begin
                  tx_line_reg  <= LINE_IDLE;
                  tx_cnt_reg   <= brg_reg;
                  tx_state_reg <= FR_STOP;
               end
            end
            FR_STOP: begin
               if (tx_tick) begin
                  tx_state_reg <= FR_IDLE;
               end
            end
            default: tx_state_reg <= FR_IDLE;
         endcase
      end
   end

   // pin is the frame line pulled low while the error signal stands
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_tx_pin <= LINE_IDLE;
      end else begin
         serial_tx_pin <= tx_line_reg & !err_sig_reg;
      end
   end

   // ---------------- receiver ----------------
   frame_state_t rx_state_reg;
   logic [15:0]  rx_cnt_reg;
   logic [2:0]   rx_idx_reg;
   logic [7:0]   rx_shift_reg;
   logic         rx_par_reg;
   logic         rx_prev_reg;
   logic         rx_ovr_reg;
   logic         rx_complete;
   logic         rx_perr;
   logic         rx_ferr;
   logic [7:0]   rx_data;
   wire          rx_tick = (rx_cnt_reg == 16'h0000);

   assign rx_complete = (rx_state_reg == FR_STOP) && rx_tick;
   assign rx_ferr     = !rx_line;
   assign rx_perr     = parity_enable
                        && ((^{rx_shift_reg, rx_par_reg}) ^ !parity_odd_even_sel);

   // undo the bit order and polarity of the line
   always_comb begin
      rx_data = bit_order_sel ? reverse8(rx_shift_reg) : rx_shift_reg;
      rx_data = rx_data ^ {8{data_invert_sel}};
   end

   // character framing on the receive side; samples are taken mid-bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_state_reg <= FR_IDLE;
         rx_cnt_reg   <= 16'h0000;
         rx_idx_reg   <= 3'h0;
         rx_shift_reg <= 8'h00;
         rx_par_reg   <= 1'b0;
         rx_prev_reg  <= LINE_IDLE;
         rx_ovr_reg   <= 1'b0;
      end else begin
         rx_prev_reg <= rx_line;
         if (!rx_tick) begin
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
         end
         case (rx_state_reg)
            FR_IDLE: begin
               rx_ovr_reg <= 1'b0;
               if (ctrl_reg[CB_RX_EN] && rx_prev_reg && !rx_line) begin
                  rx_cnt_reg   <= {1'b0, brg_reg[15:1]};
                  rx_state_reg <= FR_START;
               end
            end
            FR_START: begin
               // a start bit gone high by mid-bit was a glitch
               if (rx_tick) begin
                  rx_cnt_reg   <= brg_reg;
                  rx_idx_reg   <= 3'h0;
                  rx_state_reg <= rx_line ? FR_IDLE : FR_DATA;
               end
            end
            FR_DATA: begin
               if (rx_tick) begin
                  rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
                  rx_cnt_reg   <= brg_reg;
                  rx_idx_reg   <= rx_idx_reg + 3'h1;
                  if (rx_idx_reg == LAST_DATA_IDX) begin
                     // eighth bit in while the last character is unread
                     rx_ovr_reg   <= rx_full_reg && !rd_rxbuf;
                     rx_state_reg <= parity_enable ? FR_PAR : FR_STOP;
                  end
               end
            end
            FR_PAR: begin
               if (rx_tick) begin
                  rx_par_reg   <= rx_line;
                  rx_cnt_reg   <= brg_reg;
                  rx_state_reg <= FR_STOP;
               end
            end
            FR_STOP: begin
               if (rx_tick) begin
                  rx_state_reg <= FR_IDLE;
               end
            end
            default: rx_state_reg <= FR_IDLE;
         endcase
      end
   end

   // receive buffer and error flags; a new event wins over a same-cycle read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_buffer   <= 8'h00;
         rx_full_reg <= 1'b0;
         oer_reg     <= 1'b0;
         fer_reg     <= 1'b0;
         per_reg     <= 1'b0;
      end else begin
         if (rd_rxbuf) begin
            rx_full_reg <= 1'b0;
            oer_reg     <= 1'b0;
            fer_reg     <= 1'b0;
            per_reg     <= 1'b0;
         end
         if (rx_complete) begin
            // on overrun the old character stays unchanged; the new one is dropped
            if (!rx_ovr_reg) begin
               rx_buffer   <= rx_data;
               rx_full_reg <= 1'b1;
            end
            if (rx_ovr_reg) oer_reg <= 1'b1;
            if (rx_ferr)    fer_reg <= 1'b1;
            if (rx_perr)    per_reg <= 1'b1;
         end
      end
   end

   // error signal starts in the stop bit of a character with a parity error, ends on a buffer read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         err_sig_reg <= 1'b0;
      end else if (rx_complete && rx_perr && error_signal_out_en) begin
         err_sig_reg <= 1'b1;
      end else if (rd_rxbuf) begin
         err_sig_reg <= 1'b0;
      end
   end

   // ---------------- interrupts ----------------
   logic [IRQ_W-1:0] ievent;
   logic [IRQ_W-1:0] iclear;

   always_comb begin
      ievent                = {IRQ_W{1'b0}};
      ievent[IB_TX_DONE]    = tx_done;
      ievent[IB_RX_DONE]    = rx_complete && !rx_ovr_reg;
      ievent[IB_RX_ERR]     = rx_complete && (rx_ovr_reg || rx_ferr || rx_perr);
      iclear = (do_write && waddr_reg == OFS_ISTAT && wstrb_reg[0])
               ? wdata_reg[IRQ_W-1:0] : {IRQ_W{1'b0}};
   end

   // sticky status, write one to clear, set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         istat_reg <= IRQ_RST;
      end else begin
         istat_reg <= (istat_reg & ~iclear) | ievent;
      end
   end

   // level interrupt, one cycle behind the status bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(istat_reg & imask_reg);
      end
   end

endmodule
`default_nettype wire

// ---- sim_card_serial_mode_properties.sv ----
// port-level checks of the smart-card serial channel
`timescale 1ns/1ps
`default_nettype none
module sim_card_serial_mode_properties
   import sim_serial_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [7:0]  awaddr,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic [31:0] wdata,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [7:0]  araddr,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic        serial_rx_pin,
   input wire logic        serial_tx_pin
);
   localparam logic [7:0] HOLE = 8'h1C;  // first offset past the map
   logic [7:0] ctrl_q;
   logic       rx_rd_q;
   logic       ar_hs;
   assign ar_hs = arvalid && arready;
   // control shadow: only sees writes whose address and data land together
   always_ff @(posedge aclk) begin
      if (!aresetn) ctrl_q <= CTRL_RST;
      else if (awvalid && awready && wvalid && wready && awaddr == OFS_CTRL) ctrl_q <= wdata[7:0];
   end
   // the pending read is of the receive buffer
   always_ff @(posedge aclk) begin
      if (!aresetn) rx_rd_q <= 1'b0;
      else if (ar_hs) rx_rd_q <= (araddr == OFS_RXBUF);
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_rd_answer; ar_hs |=> rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("no read answer");
   property p_rd_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
   property p_hole; ar_hs && araddr == HOLE |=> rresp == RESP_SLVERR && rdata == 32'h0; endproperty
   a_hole: assert property (p_hole) else $error("unmapped read not refused");
   property p_idle_reset; $rose(aresetn) |-> serial_tx_pin; endproperty
   a_idle_reset: assert property (p_idle_reset) else $error("line low after reset");
   property p_quiet; !ctrl_q[CB_TX_EN] && !ctrl_q[CB_ERE] |-> serial_tx_pin; endproperty
   a_quiet: assert property (p_quiet) else $error("line driven while off");
   property p_release;
      ar_hs && araddr == OFS_RXBUF && !ctrl_q[CB_TX_EN] |-> ##[1:3] serial_tx_pin;
   endproperty
   a_release: assert property (p_release) else $error("line not released");
   property p_sum; rvalid && rx_rd_q |-> rdata[RB_SUM] == |rdata[RB_PAR:RB_OVR]; endproperty
   a_sum: assert property (p_sum) else $error("summary flag wrong");
   property p_pin_level;
      $stable(serial_rx_pin)[*8] ##1 (ar_hs && araddr == OFS_STAT)
         |=> rdata[SB_RX_PIN] == $past(serial_rx_pin);
   endproperty
   a_pin_level: assert property (p_pin_level) else $error("pin level unreadable");
   c_release: cover property (ar_hs && araddr == OFS_RXBUF && !serial_tx_pin);
   c_hole: cover property (rvalid && rresp == RESP_SLVERR);
   c_pin_low: cover property (ar_hs && araddr == OFS_STAT && !serial_rx_pin);
endmodule
bind sim_card_serial_mode sim_card_serial_mode_properties chk (.aclk, .aresetn, .awaddr,
   .awvalid, .awready, .wdata, .wvalid, .wready, .araddr, .arvalid, .arready, .rdata,
   .rresp, .rvalid, .rready, .serial_rx_pin, .serial_tx_pin);
`default_nettype wire

// ---- card_model.sv ----
// behavioural smart card on the pulled-up serial line
`timescale 1ns/1ps
`default_nettype none
module card_model #(parameter int PER = 8) (
   input  wire logic       aclk,
   input  wire logic       tx_line,
   output var logic        rx_line,
   output var logic [9:0]  got,
   output var logic        got_stb
);
   bit sending = 1'b0;
   initial rx_line = 1'b1;
   initial got_stb = 1'b0;
   // start, data and parity, stop, then g idle bits; the model drives idle high itself
   task automatic send(input logic [8:0] b, input int g);
      sending = 1'b1;
      for (int i = 0; i < 11 + g; i++) begin
         @(posedge aclk);
         rx_line <= (i == 0) ? 1'b0 : (i < 10) ? b[i-1] : 1'b1;
         repeat (PER - 1) @(posedge aclk);
      end
      sending = 1'b0;
   endtask
   task automatic hold(input logic v);
      @(posedge aclk);
      rx_line <= v;
   endtask
   // decode frames; the error signal falls while we send, so it is no start bit
   always @(negedge tx_line) begin
      if (!sending) begin
         repeat (PER / 2) @(posedge aclk);
         for (int i = 0; i < 10; i++) begin
            repeat (PER) @(posedge aclk);
            got[i] <= tx_line;
         end
         got_stb <= 1'b1;
         @(posedge aclk);
         got_stb <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- sim_card_serial_mode_test.sv ----
// self-checking bench of the smart-card serial channel
`timescale 1ns/1ps
`default_nettype none
module sim_card_serial_mode_test import sim_serial_pkg::*;;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, serial_rx_pin, serial_tx_pin;
   logic        irq, got_stb;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [9:0]  got;
   logic [65:0] note;
   logic [65:0] rq[$];
   logic [1:0]  bq[$];
   logic [9:0]  fq[$];
   int          fail_count = 0;
   int          tests_run = 0;
   always #10 aclk = ~aclk;
   sim_card_serial_mode dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
      .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .serial_rx_pin, .serial_tx_pin, .irq);
   card_model #(.PER(8)) card (.aclk, .tx_line(serial_tx_pin), .rx_line(serial_rx_pin),
      .got, .got_stb);
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cmp_pin(input logic g, input logic e);
      cmp({31'h0, g}, {31'h0, e});
   endtask
   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // line order of the eight data bits plus parity, as the card sees them
   function automatic logic [8:0] lbits(input logic [7:0] d, input logic inv);
      logic [7:0] x;
      x = inv ? ~{d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]} : d;
      return {^x ^ inv, x};
   endfunction
   // each channel is released at its own handshake edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      bq.push_back(r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d,
                     input logic [1:0] r);
      rq.push_back({r, m, d});
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'($urandom);
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      if (!rready) begin
         rready <= 1'b1;
         @(posedge aclk);
      end
      rready <= 1'b0;
   endtask
   // take the oldest note whenever a result is accepted by a handshake or a frame strobe
   always @(posedge aclk) begin
      if (rvalid && rready) begin
         note = rq.pop_front();
         cmp(rdata & note[63:32], note[31:0]);
         cmp({30'h0, rresp}, {30'h0, note[65:64]});
      end
      if (bvalid && bready) cmp({30'h0, bresp}, {30'h0, bq.pop_front()});
      if (got_stb) cmp({22'h0, got}, {22'h0, fq.pop_front()});
   end
   // a hang costs a mismatch
   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      give_verdict();
   end
   initial begin
      logic [7:0] d;
      void'($urandom(32'h40047874));
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_CTRL, 32'hFF, {24'h0, CTRL_RST}, RESP_OKAY);
      rd(OFS_BRG, 32'hFFFF, {16'h0, BRG_RST}, RESP_OKAY);
      rd(OFS_STAT, 32'h1F, 32'h0B, RESP_OKAY);
      wr(8'h1C, 32'h1, RESP_SLVERR);
      rd(8'h1C, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
      wr(OFS_STAT, 32'h0, RESP_SLVERR);
      wr(OFS_BRG, 32'h7, RESP_OKAY);
      // direct then inverse: two sends, then good and bad receives
      for (int f = 0; f < 2; f++) begin
         wr(OFS_CTRL, f ? 32'h77 : 32'h4F, RESP_OKAY);
         for (int k = 0; k < 2; k++) begin
            d = 8'($urandom);
            fq.push_back({1'b1, lbits(d, f[0])});
            wr(OFS_TXBUF, {24'h0, d}, RESP_OKAY);
         end
         for (int i = 0; i < 400 && fq.size() > 0; i++) @(posedge aclk);
         cmp(fq.size(), 0);
         repeat (8) @(posedge aclk);
         wr(OFS_CTRL, f ? 32'h76 : 32'h4E, RESP_OKAY);
         for (int e = 0; e < 2; e++) begin
            d = 8'($urandom);
            card.send(lbits(d, f[0]) ^ {e[0], 8'h0}, 2);
            cmp_pin(serial_tx_pin, !e[0]);
            rd(OFS_STAT, 32'h10, {27'h0, e[0], 4'h0}, RESP_OKAY);
            rd(OFS_RXBUF, 32'hF0FF, {16'h0, e[0], e[0], 6'h0, d}, RESP_OKAY);
            repeat (3) @(posedge aclk);
            cmp_pin(serial_tx_pin, 1'b1);
         end
      end
      // interrupt held back by the mask, raised, then cleared
      rd(OFS_ISTAT, 32'h3, 32'h3, RESP_OKAY);
      cmp_pin(irq, 1'b0);
      wr(OFS_IMASK, 32'h7, RESP_OKAY);
      repeat (2) @(posedge aclk);
      cmp_pin(irq, 1'b1);
      wr(OFS_ISTAT, 32'h7, RESP_OKAY);
      repeat (2) @(posedge aclk);
      cmp_pin(irq, 1'b0);
      // second character before the first is read
      wr(OFS_CTRL, 32'h0E, RESP_OKAY);
      card.send(lbits(8'h3C, 1'b0) ^ 9'h100, 1);
      wr(OFS_ISTAT, 32'h7, RESP_OKAY);
      card.send(lbits(8'hA5, 1'b0), 2);
      rd(OFS_ISTAT, 32'h2, 32'h0, RESP_OKAY);
      rd(OFS_RXBUF, 32'hF000, 32'hD000, RESP_OKAY);
      // card holds its line low; software must still see the level
      wr(OFS_CTRL, 32'h0, RESP_OKAY);
      card.hold(1'b0);
      repeat (8) @(posedge aclk);
      rd(OFS_STAT, 32'h8, 32'h0, RESP_OKAY);
      card.hold(1'b1);
      repeat (4) @(posedge aclk);
      give_verdict();
   end
endmodule
`default_nettype wire
